// file: frame_path_pkg.sv
package frame_path_pkg;
	localparam int RX_DEPTH_BYTES = 16384;
	localparam int RX_ADDR_W      = 14;
	localparam int READ_ALL_MAX   = 64;
	localparam int READ_CNT_W     = 7;
	localparam int PLAY_DEPTH     = 2048;
	localparam int PLAY_ADDR_W    = 11;
	localparam int BYTE_W         = 8;
	localparam int ENTRY_W        = 9;
	localparam int LAST_POS       = 8;
endpackage : frame_path_pkg

module skid_buf #(
	parameter int WIDTH = 9
) (
	input  wire logic             ref_clk,
	input  wire logic             srst,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	logic             out_valid_ff;
	logic [WIDTH-1:0] out_data_ff;
	logic             spare_valid_ff;
	logic [WIDTH-1:0] spare_data_ff;
	logic             nxt_out_valid;
	logic [WIDTH-1:0] nxt_out_data;
	logic             nxt_spare_valid;
	logic [WIDTH-1:0] nxt_spare_data;

	// Second entry catches the word in flight when the sink stalls
	assign in_ready  = ~spare_valid_ff;
	assign out_valid = out_valid_ff;
	assign out_data  = out_data_ff;

	always_comb begin
		nxt_out_valid   = out_valid_ff;
		nxt_out_data    = out_data_ff;
		nxt_spare_valid = spare_valid_ff;
		nxt_spare_data  = spare_data_ff;
		if (!out_valid_ff || out_ready) begin
			if (spare_valid_ff) begin
				nxt_out_valid   = 1'b1;
				nxt_out_data    = spare_data_ff;
				nxt_spare_valid = 1'b0;
			end else begin
				nxt_out_valid = in_valid;
				nxt_out_data  = in_data;
			end
		end else if (in_valid && !spare_valid_ff) begin
			nxt_spare_valid = 1'b1;
			nxt_spare_data  = in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			out_valid_ff   <= 1'b0;
			out_data_ff    <= '0;
			spare_valid_ff <= 1'b0;
			spare_data_ff  <= '0;
		end else begin
			out_valid_ff   <= nxt_out_valid;
			out_data_ff    <= nxt_out_data;
			spare_valid_ff <= nxt_spare_valid;
			spare_data_ff  <= nxt_spare_data;
		end
	end
endmodule : skid_buf

// file: frame_path.sv
module frame_path #(
	parameter int RX_DEPTH = frame_path_pkg::RX_DEPTH_BYTES,
	parameter int RX_AW    = frame_path_pkg::RX_ADDR_W,
	parameter int PL_DEPTH = frame_path_pkg::PLAY_DEPTH,
	parameter int PL_AW    = frame_path_pkg::PLAY_ADDR_W
) (
	input  wire logic       ref_clk,
	input  wire logic       srst,
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_last,
	input  wire logic       rx_err,
	input  wire logic       fifo_loopback,
	input  wire logic       flush,
	input  wire logic       read_one,
	input  wire logic       read_all,
	output logic            host_valid,
	output logic      [7:0] host_data,
	output logic            host_last,
	input  wire logic       host_ready,
	output logic            read_busy,
	output logic [RX_AW:0]  rx_frame_count,
	output logic            rx_drop_event,
	input  wire logic       player_select,
	input  wire logic       repeat_mode,
	input  wire logic       load_clear,
	input  wire logic       load_valid,
	input  wire logic [7:0] load_data,
	input  wire logic       load_last,
	input  wire logic       send_cmd,
	input  wire logic       stop_cmd,
	output logic            tx_valid,
	output logic      [7:0] tx_data,
	output logic            tx_last,
	input  wire logic       tx_ready,
	output logic            player_busy
);
	localparam logic [RX_AW:0] DEPTH_W = (RX_AW+1)'(RX_DEPTH);
	localparam logic [frame_path_pkg::READ_CNT_W-1:0] ALL_MAX =
		frame_path_pkg::READ_CNT_W'(frame_path_pkg::READ_ALL_MAX);
	default clocking chk_cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	typedef enum logic {PL_IDLE, PL_RUN} play_state_t;
	// Receive store: {last, data} per byte keeps frame boundaries
	logic [frame_path_pkg::ENTRY_W-1:0] rx_mem [RX_DEPTH];
	logic [frame_path_pkg::ENTRY_W-1:0] pl_mem [PL_DEPTH];

	logic [RX_AW:0] wr_ptr_ff, nxt_wr_ptr;
	logic [RX_AW:0] commit_ff, nxt_commit;
	logic [RX_AW:0] rd_ptr_ff, nxt_rd_ptr;
	logic [RX_AW:0] cnt_ff, nxt_cnt;
	logic           drop_ff, nxt_drop;
	logic           in_frame_ff, nxt_in_frame;
	logic           drop_evt_ff, nxt_drop_evt;
	logic           busy_ff, nxt_busy;
	logic [frame_path_pkg::READ_CNT_W-1:0] left_ff, nxt_left;
	logic [RX_AW:0] used;
	logic           full, drop_now, commit_evt;
	logic           rxb_in_ready, pop, pop_last;
	logic [frame_path_pkg::ENTRY_W-1:0] rd_word;
	logic [frame_path_pkg::ENTRY_W-1:0] host_word;

	assign used     = wr_ptr_ff - rd_ptr_ff;
	assign full     = (used == DEPTH_W);
	// no partial frame, flush drops in-flight frame
	assign drop_now = drop_ff | full | flush;
	assign commit_evt = rx_valid & rx_last & ~drop_now & ~rx_err;
	assign rd_word  = rx_mem[rd_ptr_ff[RX_AW-1:0]];
	assign pop      = busy_ff & rxb_in_ready & (cnt_ff != '0);
	assign pop_last = pop & rd_word[frame_path_pkg::LAST_POS];

	// Write side
	always_comb begin
		nxt_wr_ptr   = wr_ptr_ff;
		nxt_commit   = commit_ff;
		nxt_drop     = drop_ff;
		nxt_in_frame = in_frame_ff;
		nxt_drop_evt = 1'b0;
		if (flush && in_frame_ff)
			nxt_drop = 1'b1;
		if (rx_valid) begin
			nxt_in_frame = ~rx_last;
			if (!drop_now)
				nxt_wr_ptr = wr_ptr_ff + 1'b1;
			if (rx_last) begin
				nxt_drop = 1'b0;
				if (drop_now || rx_err) begin
					nxt_wr_ptr   = commit_ff;
					nxt_drop_evt = 1'b1;
				end else begin
					nxt_commit = wr_ptr_ff + 1'b1;
				end
			end else begin
				nxt_drop = drop_now;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wr_ptr_ff   <= '0;
			commit_ff   <= '0;
			drop_ff     <= 1'b0;
			in_frame_ff <= 1'b0;
			drop_evt_ff <= 1'b0;
		end else begin
			wr_ptr_ff   <= nxt_wr_ptr;
			commit_ff   <= nxt_commit;
			drop_ff     <= nxt_drop;
			in_frame_ff <= nxt_in_frame;
			drop_evt_ff <= nxt_drop_evt;
		end
	end

	// Memory write; never past read pointer
	always_ff @(posedge ref_clk) begin
		if (rx_valid && !drop_now)
			rx_mem[wr_ptr_ff[RX_AW-1:0]] <= {rx_last, rx_data};
	end

	// Read side
	always_comb begin
		nxt_rd_ptr = rd_ptr_ff;
		nxt_cnt    = cnt_ff;
		nxt_busy   = busy_ff;
		nxt_left   = left_ff;
		if (pop)
			nxt_rd_ptr = rd_ptr_ff + 1'b1;
		// Commit and last-byte pop in the same cycle cancel out
		nxt_cnt = cnt_ff + {{RX_AW{1'b0}}, commit_evt}
			- {{RX_AW{1'b0}}, pop_last};
		if (pop_last) begin
			nxt_left = left_ff - 1'b1;
			if (left_ff == 1)
				nxt_busy = 1'b0;
		end
		if (!busy_ff && !fifo_loopback && cnt_ff != '0) begin
			if (read_one) begin
				nxt_busy = 1'b1;
				nxt_left = frame_path_pkg::READ_CNT_W'(1);
			end else if (read_all) begin
				nxt_busy = 1'b1;
				nxt_left = (cnt_ff > (RX_AW+1)'(ALL_MAX)) ? ALL_MAX
					: cnt_ff[frame_path_pkg::READ_CNT_W-1:0];
			end
		end
		if (flush) begin
			nxt_rd_ptr = commit_ff;
			nxt_cnt    = '0;
			nxt_busy   = 1'b0;
			nxt_left   = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rd_ptr_ff <= '0;
			cnt_ff    <= '0;
			busy_ff   <= 1'b0;
			left_ff   <= '0;
		end else begin
			rd_ptr_ff <= nxt_rd_ptr;
			cnt_ff    <= nxt_cnt;
			busy_ff   <= nxt_busy;
			left_ff   <= nxt_left;
		end
	end

	skid_buf #(
		.WIDTH(frame_path_pkg::ENTRY_W)
	) u_host_buf (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.in_valid (pop),
		.in_data  (rd_word),
		.in_ready (rxb_in_ready),
		.out_valid(host_valid),
		.out_data (host_word),
		.out_ready(host_ready)
	);

	assign host_data      = host_word[frame_path_pkg::BYTE_W-1:0];
	assign host_last      = host_word[frame_path_pkg::LAST_POS];
	assign read_busy      = busy_ff;
	assign rx_frame_count = cnt_ff;
	assign rx_drop_event  = drop_evt_ff;
	// Frame player
	play_state_t      st_ff, nxt_st;
	logic [PL_AW-1:0] pa_ff, nxt_pa;
	logic [PL_AW:0]   end_ff, nxt_end;
	logic             stop_pend_ff, nxt_stop_pend;
	logic             txb_in_ready, push, at_end, frame_end;
	logic [frame_path_pkg::ENTRY_W-1:0] pl_word;
	logic [frame_path_pkg::ENTRY_W-1:0] tx_word;

	assign pl_word   = pl_mem[pa_ff];
	assign push      = (st_ff == PL_RUN) & txb_in_ready;
	assign at_end    = ({1'b0, pa_ff} == end_ff - 1'b1);
	// Final loaded byte always closes a frame
	assign frame_end = pl_word[frame_path_pkg::LAST_POS] | at_end;

	always_comb begin
		nxt_st        = st_ff;
		nxt_pa        = pa_ff;
		nxt_end       = end_ff;
		nxt_stop_pend = stop_pend_ff;
		case (st_ff)
			PL_IDLE: begin
				nxt_stop_pend = 1'b0;
				// Loading only while idle keeps RAM stable
				if (load_clear)
					nxt_end = '0;
				else if (load_valid && end_ff != (PL_AW+1)'(PL_DEPTH))
					nxt_end = end_ff + 1'b1;
				if (send_cmd && player_select && end_ff != '0) begin
					nxt_st = PL_RUN;
					nxt_pa = '0;
				end
			end
			PL_RUN: begin
				if (stop_cmd || !player_select)
					nxt_stop_pend = 1'b1;
				if (push) begin
					nxt_pa = pa_ff + 1'b1;
					if (frame_end && (stop_pend_ff || stop_cmd
						|| !player_select)) begin
						nxt_st = PL_IDLE;
					end else if (at_end) begin
						nxt_pa = '0;
						if (!repeat_mode)
							nxt_st = PL_IDLE;
					end
				end
			end
			default: nxt_st = PL_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_ff        <= PL_IDLE;
			pa_ff        <= '0;
			end_ff       <= '0;
			stop_pend_ff <= 1'b0;
		end else begin
			st_ff        <= nxt_st;
			pa_ff        <= nxt_pa;
			end_ff       <= nxt_end;
			stop_pend_ff <= nxt_stop_pend;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (st_ff == PL_IDLE && load_valid && !load_clear
			&& end_ff != (PL_AW+1)'(PL_DEPTH))
			pl_mem[end_ff[PL_AW-1:0]] <= {load_last, load_data};
	end

	skid_buf #(
		.WIDTH(frame_path_pkg::ENTRY_W)
	) u_tx_buf (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.in_valid (push),
		.in_data  ({frame_end, pl_word[frame_path_pkg::BYTE_W-1:0]}),
		.in_ready (txb_in_ready),
		.out_valid(tx_valid),
		.out_data (tx_word),
		.out_ready(tx_ready)
	);

	assign tx_data     = tx_word[frame_path_pkg::BYTE_W-1:0];
	assign tx_last     = tx_word[frame_path_pkg::LAST_POS];
	assign player_busy = (st_ff == PL_RUN);

	// Checks
	a_drop_no_store: assert property (rx_valid && rx_last && drop_now
		&& !pop_last |=> cnt_ff == 0 || cnt_ff == $past(cnt_ff))
		else $error("dropped frame was counted");
	a_space_bound: assert property (used <= DEPTH_W)
		else $error("receive store overfilled");
	a_fitting_kept: assert property (commit_evt && !pop_last && !flush
		|=> cnt_ff == $past(cnt_ff) + 1) else $error("fitting frame lost");
	a_flush_empties: assert property (flush |=> cnt_ff == 0 && !busy_ff
		&& rd_ptr_ff == $past(commit_ff)) else $error("flush kept data");
	a_read_all_cap: assert property (!busy_ff && read_all && !read_one
		&& !fifo_loopback && !flush && cnt_ff > 64 |=> left_ff == 64)
		else $error("read-all not capped at 64");
	a_read_one_start: assert property (!busy_ff && read_one
		&& !fifo_loopback && !flush && cnt_ff != 0
		|=> busy_ff && left_ff == 1) else $error("single read not started");
	a_loop_refused: assert property (!busy_ff && fifo_loopback
		|=> !busy_ff) else $error("read started during loopback");
	a_send_starts: assert property (st_ff == PL_IDLE && send_cmd
		&& player_select && end_ff != 0 |=> st_ff == PL_RUN && pa_ff == 0)
		else $error("send did not start player");
	a_halt_stops: assert property (push && at_end && !repeat_mode
		|=> st_ff == PL_IDLE) else $error("halt mode kept playing");
	a_repeat_wraps: assert property (push && at_end && repeat_mode
		&& !stop_pend_ff && !stop_cmd && player_select
		|=> st_ff == PL_RUN && pa_ff == 0) else $error("repeat did not wrap");
	a_stop_boundary: assert property (st_ff == PL_RUN
		&& !(push && frame_end) |=> st_ff == PL_RUN)
		else $error("player stopped mid-frame");
	// Deselect is seen one cycle before the pending flag rises
	a_play_source: assert property (push
		|-> player_select || stop_pend_ff || $past(player_select))
		else $error("player sent while not selected");
	c_drop: cover property (drop_evt_ff ##[1:100] commit_evt);
	c_read_all: cover property (busy_ff && left_ff > 1 ##[1:200] !busy_ff);
	c_repeat: cover property (push && at_end && repeat_mode
		##1 st_ff == PL_RUN);
	c_stop: cover property (stop_cmd && st_ff == PL_RUN
		##[1:100] st_ff == PL_IDLE);
endmodule : frame_path

// file: mac_model.sv
module mac_model (
	input  wire logic       ref_clk,
	output logic            rx_valid,
	output logic      [7:0] rx_data,
	output logic            rx_last,
	output logic            rx_err,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	output logic            tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       slow = 1'b0;
	int         n_tx_last = 0;
	logic [7:0] tx_q[$];

	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_last = 1'b0;
		rx_err = 1'b0;
		tx_ready = 1'b1;
	end

	// No back-pressure on receive: bytes go out back to back
	task automatic rx_frame(input int len, input logic [7:0] tag,
			input logic bad);
		for (int i = 0; i < len; i++) begin
			@(posedge ref_clk);
			rx_valid <= 1'b1;
			rx_data <= tag + 8'(i);
			rx_last <= (i == len - 1);
			rx_err <= bad && (i == len - 1);
		end
		@(posedge ref_clk);
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		rx_err <= 1'b0;
		// Stale data must not look valid
		rx_data <= ~rx_data;
	endtask : rx_frame

	always @(posedge ref_clk) begin
		if (tx_valid && tx_ready) begin
			tx_q.push_back(tx_data);
			n_tx_last += int'(tx_last);
		end
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
endmodule : mac_model

// file: rx_frame_fifo_and_frame_player_bench.sv
module rx_frame_fifo_and_frame_player_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic       ref_clk = 1'b0;
	logic       srst = 1'b1;
	logic       rx_valid, rx_last, rx_err, tx_ready;
	logic [7:0] rx_data;
	logic       fifo_loopback = 1'b0, flush = 1'b0;
	logic       read_one = 1'b0, read_all = 1'b0, host_ready = 1'b0;
	logic       player_select = 1'b0, repeat_mode = 1'b0;
	logic       load_clear = 1'b0, load_valid = 1'b0, load_last = 1'b0;
	logic [7:0] load_data = 8'h00;
	logic       send_cmd = 1'b0, stop_cmd = 1'b0;
	logic       host_valid, host_last, read_busy, rx_drop_event;
	logic       tx_valid, tx_last, player_busy;
	logic [7:0] host_data, tx_data;
	logic [7:0] rx_frame_count;
	logic [7:0] hq[$];
	int         n_hl = 0, drops = 0, cyc = 0;
	int         failures = 0, n_compared = 0;
	localparam int CMD_READ_ONE = 0, CMD_READ_ALL = 1, CMD_FLUSH = 2;
	localparam int CMD_LOAD_CLEAR = 3, CMD_SEND = 4, CMD_STOP = 5;

	// Small store keeps the fill and the 64-frame cap short
	frame_path #(.RX_DEPTH(128), .RX_AW(7), .PL_DEPTH(32), .PL_AW(5)) u_dut (
		.ref_clk, .srst, .rx_valid, .rx_data, .rx_last, .rx_err,
		.fifo_loopback, .flush, .read_one, .read_all, .host_valid,
		.host_data, .host_last, .host_ready, .read_busy, .rx_frame_count,
		.rx_drop_event, .player_select, .repeat_mode, .load_clear,
		.load_valid, .load_data, .load_last, .send_cmd, .stop_cmd,
		.tx_valid, .tx_data, .tx_last, .tx_ready, .player_busy);

	mac_model u_mac (.ref_clk, .rx_valid, .rx_data, .rx_last, .rx_err,
		.tx_valid, .tx_data, .tx_last, .tx_ready);

	always #50 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cyc++;
		host_ready <= ~host_ready;
		if (host_valid && host_ready) begin
			hq.push_back(host_data);
			n_hl += int'(host_last);
		end
		if (rx_drop_event) begin
			drops++;
		end
		if (cyc == 30000) begin
			failures++;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
		end
	endtask : check

	// One-cycle strobe on the selected control input
	task automatic pulse(input int sel);
		for (int v = 1; v >= 0; v--) begin
			@(posedge ref_clk);
			case (sel)
				CMD_READ_ONE:   read_one <= 1'(v);
				CMD_READ_ALL:   read_all <= 1'(v);
				CMD_FLUSH:      flush <= 1'(v);
				CMD_LOAD_CLEAR: load_clear <= 1'(v);
				CMD_SEND:       send_cmd <= 1'(v);
				default:        stop_cmd <= 1'(v);
			endcase
		end
	endtask : pulse

	// Bounded wait for both engines to go idle, then drain the buffers
	task automatic settle();
		int k;
		k = 0;
		repeat (2) @(posedge ref_clk);
		while ((read_busy | player_busy) !== 1'b0 && k < 3000) begin
			@(posedge ref_clk);
			k++;
		end
		repeat (6) @(posedge ref_clk);
	endtask : settle

	task automatic load(input int len, input logic [7:0] tag);
		for (int i = 0; i < len; i++) begin
			@(posedge ref_clk);
			load_valid <= 1'b1;
			load_data <= tag + 8'(i);
			load_last <= (i == len - 1);
		end
		@(posedge ref_clk);
		load_valid <= 1'b0;
	endtask : load

	task automatic end_of_test();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		u_mac.rx_frame(60, 8'h00, 1'b0);
		u_mac.rx_frame(60, 8'h40, 1'b0);
		u_mac.rx_frame(10, 8'h80, 1'b0);
		u_mac.rx_frame(8, 8'hC0, 1'b0);
		u_mac.rx_frame(1, 8'hF0, 1'b0);
		settle();
		check(rx_frame_count, 3);
		check(drops, 2);
		$display("test fill done");
		pulse(CMD_READ_ONE);
		settle();
		check(hq.size(), 60);
		check(hq[59], 8'h3B);
		check(n_hl, 1);
		check(rx_frame_count, 2);
		fifo_loopback <= 1'b1;
		pulse(CMD_READ_ALL);
		repeat (3) @(posedge ref_clk);
		check(read_busy, 0);
		fifo_loopback <= 1'b0;
		hq.delete();
		n_hl = 0;
		pulse(CMD_READ_ALL);
		settle();
		check(hq.size(), 68);
		check(hq[67], 8'hC7);
		check(n_hl, 2);
		$display("test read done");
		u_mac.rx_frame(20, 8'h00, 1'b0);
		// Flush lands inside the second frame: store empties, frame dropped
		fork
			u_mac.rx_frame(20, 8'h00, 1'b0);
			begin
				repeat (5) @(posedge ref_clk);
				pulse(CMD_FLUSH);
			end
		join
		settle();
		check(rx_frame_count, 0);
		check(drops, 3);
		u_mac.rx_frame(5, 8'h00, 1'b1);
		for (int i = 0; i < 66; i++) begin
			u_mac.rx_frame(1, 8'(i), 1'b0);
		end
		settle();
		check(rx_frame_count, 66);
		check(drops, 4);
		hq.delete();
		n_hl = 0;
		pulse(CMD_READ_ALL);
		settle();
		check(n_hl, 64);
		check(hq[63], 8'h3F);
		check(rx_frame_count, 2);
		$display("test flush and cap done");
		player_select <= 1'b1;
		pulse(CMD_LOAD_CLEAR);
		load(3, 8'h10);
		load(2, 8'h20);
		u_mac.slow <= 1'b1;
		pulse(CMD_SEND);
		settle();
		check(u_mac.tx_q.size(), 5);
		check(u_mac.tx_q[4], 8'h21);
		check(u_mac.n_tx_last, 2);
		$display("test halt done");
		u_mac.tx_q.delete();
		u_mac.n_tx_last = 0;
		repeat_mode <= 1'b1;
		pulse(CMD_SEND);
		repeat (41) @(posedge ref_clk);
		pulse(CMD_STOP);
		settle();
		check(player_busy, 0);
		check(u_mac.n_tx_last > 2, 1);
		// Last byte out must close a frame
		check(u_mac.tx_q[$] == 8'h12 || u_mac.tx_q[$] == 8'h21, 1);
		$display("test repeat done");
		// Deselecting mid-run acts as a stop at the frame end
		u_mac.tx_q.delete();
		pulse(CMD_SEND);
		repeat (23) @(posedge ref_clk);
		player_select <= 1'b0;
		settle();
		check(player_busy, 0);
		check(u_mac.tx_q[$] == 8'h12 || u_mac.tx_q[$] == 8'h21, 1);
		$display("test deselect done");
		end_of_test();
	end
endmodule : rx_frame_fifo_and_frame_player_bench
